// >>> ts_mode_config.sv
`timescale 1ns/1ps
`include "ts_regs.svh"

// How it works
// RQ1: Tuning suppresses windows unless debug bit set; the code does this in streaming mode only, event mode ignores tuning.
// RQ2: Host pulling ready low forces a window.
// RQ3: Stability bit lengthens analogue settling time.
// RQ4: Freeze holds averages, blocks reseed and retune.
// RQ5: Watchdog resets on silence unless disabled.
// RQ6: Streaming by default; event bit limits windows.
// RQ7: Each qualifying event pulses ready low once.
// RQ8: Trackpad touch forces window every charge cycle.
// RQ9: Host polls or uses ready handshake.
// RQ10: Two-bit field picks average tracking speed.
// RQ11: Count filter select; enabling lengthens sampling.
// RQ12: Wake-both bit wakes on either direction.
// RQ13: Autoclear bit clears pad flags per window.
// RQ14: Full-scan segments every N low-power periods.
// RQ15: Reset flag set after every reset.
// RQ16: Writing acknowledge bit clears reset flag.
// RQ17: Off mode powers down; data line wakes.
// RQ18: Bias bit selects higher receive bias current.
// RQ19: Float bit floats idle lines, else grounded.
// RQ20: Halt bit stops conversions; ready toggle resumes.
// RQ21: Spread bit charges self and receive pins.
// RQ22: Pad transfer 2 MHz, slow bit 1 MHz.

module ts_mode_config
    import ts_pkg::*;
#(
    parameter int unsigned COMMS_CYCLES = `TS_COMMS_TIME_NS / `TS_CLK_NS,
    parameter int unsigned WDT_CYCLES   = `TS_WDT_TIME_NS / `TS_CLK_NS
) (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    input  wire logic       rdy_in,
    output logic            rdy_out,
    output logic            rdy_oe_n,
    input  wire logic       cycle_done,
    input  wire logic       tuning_active,
    input  wire logic       pad_touch,
    input  wire logic [9:0] event_pulse,
    input  wire logic       filter_halt,
    input  wire logic       adjust_req,
    input  wire logic       low_power,
    input  wire logic       lp_tick,
    output logic            settle_long,
    output logic            track_en,
    output logic            adjust_go,
    output logic [1:0]      average_track_speed,
    output logic [1:0]      count_filter_select,
    output logic            sample_long,
    output logic            wake_both,
    output logic            pad_flag_clear,
    output logic            full_scan_go,
    output logic            power_down,
    output logic            conv_halt,
    output logic            bias_high,
    output logic            idle_line_float,
    output logic            spread_self_channel,
    output logic            xfer_tick,
    output logic            dev_reset,
    output logic            show_reset
);

    localparam logic [4:0] FAST_DIV = 5'(`TS_CLK_HZ / `TS_XFER_FAST_HZ);
    localparam logic [4:0] SLOW_DIV = 5'(`TS_CLK_HZ / `TS_XFER_SLOW_HZ);
    localparam logic [23:0] COMMS_LAST = 24'(COMMS_CYCLES - 1);
    localparam logic [23:0] WDT_LAST   = 24'(WDT_CYCLES - 1);

    ts_cfg_reg_type q;
    ts_cfg_reg_type d;
    logic           wr_en;
    logic           wr_hi;
    logic [7:0]     wr_addr;
    logic [7:0]     wr_data;
    logic [7:0]     rd_addr;
    logic           rd_hi;
    logic [7:0]     rd_byte;
    logic [15:0]    rd_word;
    logic [15:0]    flags_word;
    logic           done;
    logic           sda_act;
    logic           ev_any;
    logic           rdy_fall;
    logic           rdy_edge;
    logic           open_req;
    logic           host_force;
    logic           soft_rst;
    logic [2:0]     seg_next;
    logic [4:0]     div_last;

    ts_i2c_port u_port (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .rd_byte  (rd_byte),
        .sda_out  (sda_out),
        .sda_oe_n (sda_oe_n),
        .wr_en    (wr_en),
        .wr_hi    (wr_hi),
        .wr_addr  (wr_addr),
        .wr_data  (wr_data),
        .rd_addr  (rd_addr),
        .rd_hi    (rd_hi),
        .done     (done),
        .sda_act  (sda_act)
    );

    // Reset flag in bit 7, halt in bit 1, tuning in bit 0; pending event above.
    assign flags_word = {7'h00, q.ev_pend, q.show_reset, 5'h00,
                         q.set_b[`TS_B_HALT], tuning_active};
    assign rd_word = (rd_addr == `TS_ADDR_FLAGS) ? flags_word :
                     (rd_addr == `TS_ADDR_SET_A) ? q.set_a :
                     (rd_addr == `TS_ADDR_SET_B) ? q.set_b : 16'h0000;
    assign rd_byte = rd_hi ? rd_word[15:8] : rd_word[7:0];

    always_comb begin
        d           = q;
        d.pad_clr   = 1'b0;
        d.dev_rst   = 1'b0;
        d.seg_go    = 1'b0;
        d.xfer_tick = 1'b0;
        d.rdy1      = rdy_in;
        d.rdy2      = q.rdy1;
        d.rdy3      = q.rdy2;
        rdy_fall    = q.rdy3 & ~q.rdy2;
        rdy_edge    = q.rdy3 ^ q.rdy2;
        ev_any      = |event_pulse;
        soft_rst    = 1'b0;

        if (wr_en && wr_addr == `TS_ADDR_SET_A) begin
            if (wr_hi) begin
                d.set_a[15:8] = wr_data;
            end else begin
                d.set_a[7:0] = wr_data;
            end
        end
        if (wr_en && wr_addr == `TS_ADDR_SET_B) begin
            if (wr_hi) begin
                d.set_b[15:8] = wr_data;
                // The acknowledge bit is a strobe and never reads back.
                d.set_b[`TS_B_ACK] = 1'b0;
                if (wr_data[`TS_B_ACK - 8]) begin
                    d.show_reset = 1'b0; // RQ16
                end
            end else begin
                d.set_b[7:0] = wr_data;
            end
        end

        // The host resumes from halt by toggling ready while we leave it alone.
        if (q.set_b[`TS_B_HALT] && q.rdy_rel && rdy_edge) begin
            d.set_b[`TS_B_HALT] = 1'b0; // RQ20
        end

        open_req = cycle_done && !q.set_b[`TS_B_HALT] && !q.set_b[`TS_B_OFF] &&
                   (q.set_a[`TS_A_EVENT] ?
                    (q.ev_pend || ev_any || pad_touch) : // RQ7 RQ8
                    (!tuning_active || q.set_a[`TS_A_DEBUG])); // RQ1 RQ6
        host_force = rdy_fall && q.rdy_rel && !q.set_b[`TS_B_HALT] &&
                     !q.set_b[`TS_B_OFF]; // RQ2

        d.ev_pend = q.ev_pend | ev_any;
        if (!q.rdy_rel) begin
            d.win_cnt = q.win_cnt + 24'h000001;
            if (done || q.win_cnt == COMMS_LAST) begin
                // An unanswered window lapses and its data is dropped.
                d.rdy_rel = 1'b1;
                d.win_cnt = 24'h000000;
                d.pad_clr = done & q.set_b[`TS_B_PADCLR]; // RQ13
            end
        end else if (open_req || host_force) begin
            d.rdy_rel = 1'b0;
            d.ev_pend = 1'b0;
        end

        if (done || q.set_a[`TS_A_WATCHDOG_DISABLE] || q.set_b[`TS_B_OFF]) begin
            d.wdt_cnt = 24'h000000; // RQ5
        end else if (q.wdt_cnt == WDT_LAST) begin
            soft_rst = 1'b1; // RQ5
        end else begin
            d.wdt_cnt = q.wdt_cnt + 24'h000001;
        end
        if (q.set_b[`TS_B_OFF] && sda_act) begin
            soft_rst = 1'b1; // RQ17
        end

        seg_next = q.seg_cnt + 3'h1;
        if (low_power && lp_tick) begin
            d.seg_cnt = seg_next;
            // A rate of zero is taken as a segment on every period.
            if (seg_next >= q.set_b[`TS_B_RATE]) begin
                d.seg_cnt = 3'h0;
                d.seg_go  = ~q.set_b[`TS_B_HALT]; // RQ14
            end
        end

        div_last = (q.set_b[`TS_B_SLOW] ? SLOW_DIV : FAST_DIV) - 5'h01; // RQ22
        if (q.div_cnt >= div_last) begin
            d.div_cnt   = 5'h00;
            d.xfer_tick = ~q.set_b[`TS_B_HALT] & ~q.set_b[`TS_B_OFF];
        end else begin
            d.div_cnt = q.div_cnt + 5'h01;
        end

        d.track_en  = ~q.set_a[`TS_A_FREEZE] & ~filter_halt; // RQ4 RQ10
        d.adjust_go = adjust_req & ~q.set_a[`TS_A_FREEZE]; // RQ4

        // Register contents are lost on every device reset.
        if (soft_rst) begin
            d.set_a      = `TS_SET_A_RST;
            d.set_b      = `TS_SET_B_RST;
            d.show_reset = 1'b1; // RQ15
            d.rdy_rel    = 1'b1;
            d.ev_pend    = 1'b0;
            d.win_cnt    = 24'h000000;
            d.wdt_cnt    = 24'h000000;
            d.dev_rst    = 1'b1;
            d.adjust_go  = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            q            <= '0;
            q.set_a      <= `TS_SET_A_RST;
            q.set_b      <= `TS_SET_B_RST;
            q.show_reset <= 1'b1; // RQ15
            q.rdy_rel    <= 1'b1;
            q.rdy1       <= 1'b1;
            q.rdy2       <= 1'b1;
            q.rdy3       <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign rdy_out             = 1'b0;
    assign rdy_oe_n            = q.rdy_rel;
    assign settle_long         = q.set_a[`TS_A_STABLE]; // RQ3
    assign track_en            = q.track_en;
    assign adjust_go           = q.adjust_go;
    assign average_track_speed = q.set_a[`TS_A_BETA]; // RQ10
    assign count_filter_select = q.set_a[`TS_A_ACF]; // RQ11
    assign sample_long         = |q.set_a[`TS_A_ACF]; // RQ11
    assign wake_both           = q.set_b[`TS_B_WAKE2]; // RQ12
    assign pad_flag_clear      = q.pad_clr;
    assign full_scan_go        = q.seg_go;
    assign power_down          = q.set_b[`TS_B_OFF]; // RQ17
    assign conv_halt           = q.set_b[`TS_B_HALT]; // RQ20
    assign bias_high           = q.set_b[`TS_B_BIAS]; // RQ18
    assign idle_line_float     = q.set_b[`TS_B_FLOAT]; // RQ19
    assign spread_self_channel = q.set_b[`TS_B_SPREAD]; // RQ21
    assign xfer_tick           = q.xfer_tick;
    assign dev_reset           = q.dev_rst;
    assign show_reset          = q.show_reset;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    AST_TUNE_QUIET: assert property ( // RQ1
        cycle_done && tuning_active && !q.set_a[`TS_A_DEBUG] && !q.set_a[`TS_A_EVENT]
        && q.rdy_rel && !host_force |=> rdy_oe_n)
        else $error("window opened during tuning without debug");
    AST_HOST_FORCE: assert property ( // RQ2
        host_force && !soft_rst |=> !rdy_oe_n [*2])
        else $error("host ready request not answered");
    AST_STREAM: assert property ( // RQ6
        cycle_done && !q.set_a[`TS_A_EVENT] && !tuning_active && q.rdy_rel
        && !q.set_b[`TS_B_HALT] && !q.set_b[`TS_B_OFF] && !soft_rst |=> !rdy_oe_n)
        else $error("streaming window missing");
    AST_EVENT_QUIET: assert property ( // RQ6
        cycle_done && q.set_a[`TS_A_EVENT] && !pad_touch && !ev_any && !q.ev_pend
        && q.rdy_rel && !host_force |=> rdy_oe_n)
        else $error("event mode window without event");
    AST_EVENT_WIN: assert property ( // RQ7
        cycle_done && q.set_a[`TS_A_EVENT] && (ev_any || pad_touch) && q.rdy_rel
        && !q.set_b[`TS_B_HALT] && !q.set_b[`TS_B_OFF] && !soft_rst |=> !rdy_oe_n)
        else $error("event or touch did not open a window");
    AST_FREEZE: assert property ( // RQ4
        q.set_a[`TS_A_FREEZE] |=> !track_en && !adjust_go)
        else $error("average moved while frozen");
    AST_WATCHDOG_DISABLE: assert property ( // RQ5
        q.set_a[`TS_A_WATCHDOG_DISABLE] && !q.set_b[`TS_B_OFF] |=> !dev_reset)
        else $error("watchdog fired while disabled");
    AST_RESET_FLAG: assert property ( // RQ15
        dev_reset |-> show_reset ##1 (show_reset || $past(wr_en)))
        else $error("reset flag not raised by reset");
    AST_ACK: assert property ( // RQ16
        wr_en && wr_hi && wr_addr == `TS_ADDR_SET_B && wr_data[`TS_B_ACK - 8]
        && !soft_rst |=> !show_reset)
        else $error("reset flag not cleared by acknowledge");
    AST_AUTOCLEAR: assert property ( // RQ13
        !q.rdy_rel && done && q.set_b[`TS_B_PADCLR] && !soft_rst
        |=> pad_flag_clear ##1 !pad_flag_clear)
        else $error("pad flags not cleared after window");
    AST_HALT_END: assert property ( // RQ20
        conv_halt && q.rdy_rel && rdy_edge && !(wr_en && wr_hi) |=> !conv_halt)
        else $error("ready toggle did not end halt");
    AST_XFER: assert property ( // RQ22
        xfer_tick |=> !xfer_tick [*8] ##1 !xfer_tick)
        else $error("transfer tick faster than 2 MHz");

    COV_FORCE: cover property (host_force ##1 !rdy_oe_n);
    COV_TIMEOUT: cover property (!q.rdy_rel && q.win_cnt == COMMS_LAST);
    COV_WDT: cover property (dev_reset && !power_down);
    COV_SEGMENT: cover property (full_scan_go);

endmodule // ts_mode_config

// >>> ts_regs.svh
`ifndef TS_REGS_SVH
`define TS_REGS_SVH

// Register addresses on the serial port.
`define TS_ADDR_FLAGS 8'h01
`define TS_ADDR_SET_A 8'h80
`define TS_ADDR_SET_B 8'h81

// Settings reset values: streaming, watchdog on, all options off.
`define TS_SET_A_RST 16'h0000
`define TS_SET_B_RST 16'h0000

// Settings word A fields.
`define TS_A_DEBUG   3
`define TS_A_STABLE  4
`define TS_A_FREEZE  5
`define TS_A_WATCHDOG_DISABLE 8
`define TS_A_EVENT   9
`define TS_A_BETA    11:10
`define TS_A_ACF     13:12

// Settings word B fields.
`define TS_B_RATE    2:0
`define TS_B_WAKE2   3
`define TS_B_PADCLR  4
`define TS_B_ACK     8
`define TS_B_OFF     9
`define TS_B_BIAS    10
`define TS_B_FLOAT   11
`define TS_B_HALT    12
`define TS_B_SPREAD  13
`define TS_B_SLOW    14

// Serial device address (arbitrary value).
`define TS_I2C_ADDR 7'h44

// Timing.
`define TS_CLK_HZ        20000000
`define TS_CLK_NS        50
`define TS_XFER_FAST_HZ  2000000
`define TS_XFER_SLOW_HZ  1000000
`define TS_COMMS_TIME_NS 2560000
`define TS_WDT_TIME_NS   100000000

`endif

// >>> ts_pkg.sv
package ts_pkg;

    typedef enum logic [5:0] {
        TS_IDLE  = 6'b000001,
        TS_ADDR  = 6'b000010,
        TS_ACK   = 6'b000100,
        TS_WRITE = 6'b001000,
        TS_READ  = 6'b010000,
        TS_RACK  = 6'b100000
    } ts_i2c_state_type;

    typedef struct packed {
        logic             scl1;
        logic             scl2;
        logic             scl3;
        logic             sda1;
        logic             sda2;
        logic             sda3;
        ts_i2c_state_type st;
        logic [3:0]       cnt;
        logic [7:0]       sh;
        logic             rw;
        logic             sel;
        logic             ptr_ok;
        logic             hi;
        logic             ack;
        logic             drv_n;
        logic [7:0]       ptr;
        logic             wr_en;
        logic             wr_hi;
        logic [7:0]       wr_addr;
        logic [7:0]       wr_data;
        logic             done;
        logic             act;
    } ts_i2c_reg_type;

    typedef struct packed {
        logic [15:0] set_a;
        logic [15:0] set_b;
        logic        show_reset;
        logic        rdy1;
        logic        rdy2;
        logic        rdy3;
        logic        rdy_rel;
        logic        ev_pend;
        logic [23:0] win_cnt;
        logic [23:0] wdt_cnt;
        logic [2:0]  seg_cnt;
        logic        seg_go;
        logic [4:0]  div_cnt;
        logic        xfer_tick;
        logic        pad_clr;
        logic        dev_rst;
        logic        track_en;
        logic        adjust_go;
    } ts_cfg_reg_type;

endpackage

// >>> ts_i2c_port.sv
`timescale 1ns/1ps
`include "ts_regs.svh"

module ts_i2c_port
    import ts_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `TS_I2C_ADDR
) (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic [7:0] rd_byte,
    output logic            sda_out,
    output logic            sda_oe_n,
    output logic            wr_en,
    output logic            wr_hi,
    output logic [7:0]      wr_addr,
    output logic [7:0]      wr_data,
    output logic [7:0]      rd_addr,
    output logic            rd_hi,
    output logic            done,
    output logic            sda_act
);

    ts_i2c_reg_type q;
    ts_i2c_reg_type d;
    logic           rise;
    logic           fall;

    always_comb begin
        d       = q;
        d.wr_en = 1'b0;
        d.done  = 1'b0;
        d.scl1  = scl_in;
        d.scl2  = q.scl1;
        d.scl3  = q.scl2;
        d.sda1  = sda_in;
        d.sda2  = q.sda1;
        d.sda3  = q.sda2;
        rise    = q.scl2 & ~q.scl3;
        fall    = ~q.scl2 & q.scl3;
        d.act   = ~q.sda2 & q.sda3;
        if (q.scl2 && q.scl3 && !q.sda2 && q.sda3) begin
            d.st     = TS_ADDR;
            d.cnt    = 4'h0;
            d.drv_n  = 1'b1;
            d.ptr_ok = 1'b0;
            d.sel    = 1'b0;
        end else if (q.scl2 && q.scl3 && q.sda2 && !q.sda3) begin
            // A stop closes a transfer; only one addressed to us counts as valid.
            d.st    = TS_IDLE;
            d.drv_n = 1'b1;
            d.done  = q.sel;
            d.sel   = 1'b0;
        end else begin
            unique case (q.st)
                TS_IDLE: begin
                end
                TS_ADDR: begin
                    if (rise) begin
                        d.sh  = {q.sh[6:0], q.sda2};
                        d.cnt = q.cnt + 4'h1;
                    end else if (fall && q.cnt == 4'h8) begin
                        if (q.sh[7:1] == DEV_ADDR) begin
                            d.st    = TS_ACK;
                            d.drv_n = 1'b0;
                            d.rw    = q.sh[0];
                            d.sel   = 1'b1;
                        end else begin
                            d.st = TS_IDLE;
                        end
                    end
                end
                TS_ACK: begin
                    if (fall) begin
                        d.drv_n = 1'b1;
                        d.cnt   = 4'h0;
                        d.st    = TS_WRITE;
                        if (q.rw) begin
                            d.st    = TS_READ;
                            d.drv_n = rd_byte[7];
                            d.sh    = {rd_byte[6:0], 1'b0};
                            d.cnt   = 4'h1;
                        end
                    end
                end
                TS_WRITE: begin
                    if (rise) begin
                        d.sh  = {q.sh[6:0], q.sda2};
                        d.cnt = q.cnt + 4'h1;
                    end else if (fall && q.cnt == 4'h8) begin
                        d.st    = TS_ACK;
                        d.drv_n = 1'b0;
                        if (q.ptr_ok) begin
                            d.wr_en   = 1'b1;
                            d.wr_addr = q.ptr;
                            d.wr_hi   = q.hi;
                            d.wr_data = q.sh;
                            d.hi      = ~q.hi;
                            d.ptr     = q.ptr + {7'h00, q.hi};
                        end else begin
                            d.ptr    = q.sh;
                            d.hi     = 1'b0;
                            d.ptr_ok = 1'b1;
                        end
                    end
                end
                TS_READ: begin
                    if (fall) begin
                        if (q.cnt == 4'h8) begin
                            d.drv_n = 1'b1;
                            d.st    = TS_RACK;
                            d.hi    = ~q.hi;
                            d.ptr   = q.ptr + {7'h00, q.hi};
                        end else begin
                            d.drv_n = q.sh[7];
                            d.sh    = {q.sh[6:0], 1'b0};
                            d.cnt   = q.cnt + 4'h1;
                        end
                    end
                end
                TS_RACK: begin
                    if (rise) begin
                        d.ack = ~q.sda2;
                    end else if (fall) begin
                        d.st = TS_IDLE;
                        if (q.ack) begin
                            d.st    = TS_READ;
                            d.drv_n = rd_byte[7];
                            d.sh    = {rd_byte[6:0], 1'b0};
                            d.cnt   = 4'h1;
                        end
                    end
                end
                default: begin
                    d.st    = TS_IDLE;
                    d.drv_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            q       <= '0;
            q.st    <= TS_IDLE;
            q.drv_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign sda_out  = 1'b0;
    assign sda_oe_n = q.drv_n;
    assign wr_en    = q.wr_en;
    assign wr_hi    = q.wr_hi;
    assign wr_addr  = q.wr_addr;
    assign wr_data  = q.wr_data;
    assign rd_addr  = q.ptr;
    assign rd_hi    = q.hi;
    assign done     = q.done;
    assign sda_act  = q.act;

endmodule // ts_i2c_port

// >>> ts_host_model.sv
`timescale 1ns/1ps
`include "ts_regs.svh"

// Host controller on the serial port and the ready line. Both lines are open
// drain with pull-ups, so a released line reads high, never the last value.
module ts_host_model (
    input  wire logic sda_oe_n,
    input  wire logic rdy_oe_n,
    output logic      scl,
    output logic      sda,
    output logic      rdy
);
    logic pull_q = 1'h0;
    logic rdy_pull_q = 1'h0;

    assign sda = ~pull_q & sda_oe_n;
    assign rdy = ~rdy_pull_q & rdy_oe_n;

    initial begin
        scl = 1'h1;
    end

    // Data only moves while the clock is low; high time is four device cycles.
    task automatic clk_bit(input logic b);
        pull_q = ~b;
        #100 scl = 1'h1;
        #200 scl = 1'h0;
        #100;
    endtask

    task automatic put(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) clk_bit(b[i]);
        clk_bit(1'h1);
    endtask

    // Polled write, no ready handshake needed outside event operation.
    task automatic write_reg(input logic [7:0] ptr, input logic [15:0] w);
        pull_q = 1'h1;
        #200 scl = 1'h0;
        #100;
        put({`TS_I2C_ADDR, 1'h0});
        put(ptr);
        put(w[7:0]);
        put(w[15:8]);
        pull_q = 1'h1;
        #100 scl = 1'h1;
        #100 pull_q = 1'h0;
        #200;
    endtask

    task automatic force_window();
        rdy_pull_q = 1'h1;
        #200 rdy_pull_q = 1'h0;
    endtask
endmodule // ts_host_model

// >>> tb_touch_sensor_mode_config.sv
`timescale 1ns/1ps
`include "ts_regs.svh"

module tb_touch_sensor_mode_config;
    import ts_pkg::*;
    localparam int unsigned COMMS = 64;
    localparam int unsigned WDT   = 2000;
    logic       ref_clk, scl, sda, rdy, sda_oe_n, rdy_oe_n, settle_long, track_en;
    logic       adjust_go, sample_long, wake_both, bias_high, idle_line_float;
    logic       spread_self_channel, xfer_tick, dev_reset, show_reset, full_scan_go, conv_halt;
    logic [1:0] average_track_speed, count_filter_select;
    logic       rstn = 1'h0, cycle_done = 1'h0, tuning_active = 1'h0, pad_touch = 1'h0;
    logic       filter_halt = 1'h0, adjust_req = 1'h0, low_power = 1'h0, lp_tick = 1'h0;
    logic [9:0] event_pulse = 10'h000;
    int         err_count, tests_run, cyc, n;

    ts_host_model i_ts_host_model (.sda_oe_n, .rdy_oe_n, .scl, .sda, .rdy);
    ts_mode_config #(.COMMS_CYCLES(COMMS), .WDT_CYCLES(WDT)) i_ts_mode_config (
        .ref_clk, .rstn, .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_n, .rdy_in(rdy),
        .rdy_out(), .rdy_oe_n, .cycle_done, .tuning_active, .pad_touch, .event_pulse,
        .filter_halt, .adjust_req, .low_power, .lp_tick, .settle_long, .track_en,
        .adjust_go, .average_track_speed, .count_filter_select, .sample_long, .wake_both,
        .pad_flag_clear(), .full_scan_go, .power_down(), .conv_halt, .bias_high,
        .idle_line_float, .spread_self_channel, .xfer_tick, .dev_reset, .show_reset);

    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Whole run needs about 4100 cycles; the ceiling leaves over twice that.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge ref_clk);
        #5;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic pulse_done();
        cycle_done = 1'h1;
        step(1);
        cycle_done = 1'h0;
        step(1);
    endtask

    task automatic tick_gap();
        n = 0;
        while (xfer_tick !== 1'h1 && n < 40) begin
            step(1);
            n++;
        end
        n = 0;
        do begin
            step(1);
            n++;
        end while (xfer_tick !== 1'h1 && n < 40);
    endtask

    task automatic t_reset();
        step(8);
        chk(show_reset, 1'h1, "rst flag");
        chk(rdy_oe_n, 1'h1, "rdy idle");
        rstn = 1'h1;
        step(2);
        pulse_done();
        chk(rdy_oe_n, 1'h0, "stream win");
        step(COMMS + 2);
        chk(rdy_oe_n, 1'h1, "win end");
        $display("test reset done");
    endtask

    task automatic t_tuning();
        tuning_active = 1'h1;
        pulse_done();
        chk(rdy_oe_n, 1'h1, "tune quiet");
        i_ts_host_model.force_window();
        step(3);
        chk(rdy_oe_n, 1'h0, "forced win");
        step(COMMS + 2);
        i_ts_host_model.write_reg(`TS_ADDR_SET_A, 16'h0008);
        step(4);
        pulse_done();
        chk(rdy_oe_n, 1'h0, "debug win");
        step(COMMS + 2);
        tuning_active = 1'h0;
        $display("test tuning done");
    endtask

    task automatic t_settings();
        i_ts_host_model.write_reg(`TS_ADDR_SET_A, 16'h2438);
        step(4);
        chk(settle_long, 1'h1, "settle");
        chk(track_en, 1'h0, "track");
        adjust_req = 1'h1;
        step(1);
        adjust_req = 1'h0;
        chk(adjust_go, 1'h0, "adjust");
        chk(average_track_speed, 2'h1, "beta");
        chk(count_filter_select, 2'h2, "acf");
        chk(sample_long, 1'h1, "sample");
        tick_gap();
        chk(n[15:0], 16'h000A, "fast xfer");
        i_ts_host_model.write_reg(`TS_ADDR_SET_B, 16'h6D08);
        step(4);
        chk(show_reset, 1'h0, "ack");
        chk({wake_both, bias_high, idle_line_float}, 3'h7, "opts");
        chk(spread_self_channel, 1'h1, "spread");
        tick_gap();
        chk(n[15:0], 16'h0014, "slow xfer");
        $display("test settings done");
    endtask

    task automatic t_event();
        i_ts_host_model.write_reg(`TS_ADDR_SET_A, 16'h0200);
        step(4);
        pulse_done();
        chk(rdy_oe_n, 1'h1, "no event");
        for (int i = 0; i < 10; i++) begin
            event_pulse = 10'h001 << i;
            step(1);
            event_pulse = 10'h000;
            pulse_done();
            chk(rdy_oe_n, 1'h0, "event win");
            step(COMMS + 2);
            pulse_done();
            chk(rdy_oe_n, 1'h1, "once");
        end
        pad_touch = 1'h1;
        pulse_done();
        chk(rdy_oe_n, 1'h0, "touch win");
        pad_touch = 1'h0;
        $display("test event done");
    endtask

    task automatic t_wdt();
        for (n = 0; n < WDT + 100 && dev_reset !== 1'h1; n++) step(1);
        chk(dev_reset, 1'h1, "wdt");
        step(2);
        chk(show_reset, 1'h1, "wdt flag");
        chk(settle_long, 1'h0, "cleared");
        $display("test watchdog done");
    endtask

    task automatic t_modes();
        i_ts_host_model.write_reg(`TS_ADDR_SET_B, 16'h0002);
        low_power = 1'h1;
        for (int i = 0; i < 2; i++) begin
            lp_tick = 1'h1;
            step(1);
            lp_tick = 1'h0;
            chk(full_scan_go, i[0], "segment");
        end
        i_ts_host_model.write_reg(`TS_ADDR_SET_B, 16'h1000);
        step(4);
        chk(conv_halt, 1'h1, "halt");
        i_ts_host_model.force_window();
        step(3);
        chk({conv_halt, rdy_oe_n}, 2'h1, "resume");
        $display("test modes done");
    endtask

    initial begin
        t_reset();
        t_tuning();
        t_settings();
        t_event();
        t_wdt();
        t_modes();
        complete_run();
    end
endmodule // tb_touch_sensor_mode_config
